//--- include/cmnd_pkg.sv
// Constants and carriers for the command-mode interpreter.
// Assumes one 25 MHz clock; bus offsets are byte addresses.
package cmnd_pkg;
  // Clock and time units
  localparam int CLK_PERIOD_NS = 40;
  localparam int MS_NS = 1_000_000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam int DSEC_MS = 100;
  localparam int LABEL_MAX = 20;
  localparam int ESC_N = 3;
  localparam int TBUF_N = 48;
  // Register byte offsets
  localparam logic [5:0] OFF_CTRL = 6'h00;
  localparam logic [5:0] OFF_IDLE = 6'h04;
  localparam logic [5:0] OFF_GUARD = 6'h08;
  localparam logic [5:0] OFF_ESC = 6'h0c;
  localparam logic [5:0] OFF_NET = 6'h10;
  localparam logic [5:0] OFF_WIN = 6'h14;
  localparam logic [5:0] OFF_STAT = 6'h18;
  localparam logic [5:0] OFF_DSTH = 6'h1c;
  localparam logic [5:0] OFF_DSTL = 6'h20;
  localparam logic [5:0] OFF_NVNET = 6'h24;
  // Reset values and ranges
  localparam logic [15:0] IDLE_RST = 16'h0064;
  localparam logic [15:0] IDLE_MIN = 16'h0002;
  localparam logic [15:0] IDLE_MAX = 16'h1770;
  localparam logic [15:0] GUARD_RST = 16'h03e8;
  localparam logic [7:0] ESC_RST = 8'h2b;
  localparam logic [15:0] NET_MAX = 16'h7fff;
  localparam logic [7:0] WIN_RST = 8'h82;
  localparam logic [7:0] WIN_MAX = 8'hfc;
  // Characters and replies
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_COMMA = 8'h2c;
  localparam logic [7:0] CH_SP = 8'h20;
  localparam logic [7:0] CH_TILDE = 8'h7e;
  localparam logic [7:0] CH_NUL = 8'h00;
  localparam logic [15:0] RES_SHORT = 16'hfffe;
  localparam logic [23:0] MSG_OK = 24'h4f4b0d;
  localparam logic [47:0] MSG_ERR = 48'h4552524f520d;
  // Command opcodes (first byte of a command line)
  localparam logic [7:0] OP_LEAVE = 8'h58;
  localparam logic [7:0] OP_SAVE = 8'h57;
  localparam logic [7:0] OP_LABEL = 8'h4c;
  localparam logic [7:0] OP_RESOLVE = 8'h52;
  localparam logic [7:0] OP_DISC = 8'h44;
  // Label string, ch[0] first
  typedef struct packed {
    logic [LABEL_MAX-1:0][7:0] ch;
    logic [4:0] len;
  } cmnd_label_t;
  localparam cmnd_label_t LABEL_RST = {{(LABEL_MAX-1){8'h00}}, CH_SP, 5'h01};
  // One node answer from the radio side
  typedef struct packed {
    logic [15:0] net;
    logic [15:0] short_addr;
    logic [63:0] serial;
    cmnd_label_t label;
    logic [15:0] parent;
    logic [7:0] dev_type;
    logic [7:0] status;
    logic [15:0] profile;
    logic [15:0] maker;
  } cmnd_node_t;
  typedef enum logic [2:0] {LD_NONE, LD_OK, LD_ERR, LD_REP, LD_FRM, LD_CR} cmnd_ld_t;
endpackage : cmnd_pkg

//--- verilog/cmnd_core.sv
// Command-mode interpreter: escape entry, timeouts, label, discovery.
// Assumes rx/tx byte streams and node answers come from same-clock logic.
//
// Our own choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
module cmnd_core
  import cmnd_pkg::*;
#(
  parameter int MS_CYC = MS_CYCLES
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  output logic tx_valid,
  output logic [7:0] tx_byte,
  input wire logic tx_ready,
  output logic disc_start,
  output logic [15:0] net_group,
  input wire logic node_valid,
  input wire cmnd_node_t node,
  output logic node_ready,
  output logic nv_save,
  output logic [15:0] nv_net_group,
  output logic cmd_mode
);
  if (MS_CYC < 2 || MS_CYC > 24'hffffff) begin : g_chk
    $error("MS_CYC out of range");
  end

  typedef enum {S_IDLE, S_OP, S_ARG, S_EXEC, S_RES, S_DISC} cmnd_st_t;

  // Bus-side state
  logic ack, next_ack;
  logic [31:0] rdata, next_rdata;
  logic api, next_api; // Framed API mode
  logic [15:0] tmo, next_tmo; // Idle timeout, 100 ms units
  logic [15:0] guard, next_guard; // Guard silence, ms
  logic [7:0] esc, next_esc;
  logic [15:0] net_id, next_net_id;
  logic [7:0] win, next_win;
  // Interpreter state
  cmnd_st_t st, next_st;
  logic [1:0] esc_n, next_esc_n; // Escapes seen
  logic [15:0] sil, next_sil; // ms since last rx byte
  logic [15:0] idle, next_idle; // 100 ms units since entry, valid command or search end
  logic [23:0] ms_cnt, next_ms_cnt;
  logic [6:0] ds_cnt, next_ds_cnt;
  logic [7:0] left, next_left; // Window left, 100 ms units
  logic [7:0] op, next_op;
  cmnd_label_t arg, next_arg;
  cmnd_label_t label, next_label;
  logic [31:0] dest_hi, next_dest_hi;
  logic [31:0] dest_lo, next_dest_lo;
  logic [TBUF_N-1:0][7:0] tbuf, next_tbuf; // Reply bytes, [0] goes first
  logic [5:0] tcnt, next_tcnt;
  logic start, next_start;
  logic nvs, next_nvs;
  logic [15:0] nvnet, next_nvnet;
  logic ms_tick, ds_tick, hit, valid_cmd;
  cmnd_ld_t ld;

  // Case-sensitive exact label match
  function automatic logic lab_eq(input cmnd_label_t a, input cmnd_label_t b);
    logic eq;
    eq = (a.len == b.len);
    for (int j = 0; j < LABEL_MAX; j++) begin
      if (j < a.len && a.ch[j] != b.ch[j]) begin
        eq = 1'b0;
      end
    end
    return eq;
  endfunction : lab_eq

  // Label must be non-empty, printable, no leading space
  function automatic logic lab_ok(input cmnd_label_t a);
    logic ok;
    ok = (a.len != 5'h00) && (a.ch[0] != CH_SP);
    for (int j = 0; j < LABEL_MAX; j++) begin
      if (j < a.len && (a.ch[j] < CH_SP || a.ch[j] > CH_TILDE)) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction : lab_ok

  // Report field value and byte count (field 3 is the label)
  function automatic logic [67:0] fld(input int f, input cmnd_node_t n);
    case (f)
      0: return {4'h2, 48'h0, n.short_addr};
      1: return {4'h4, 32'h0, n.serial[63:32]};
      2: return {4'h4, 32'h0, n.serial[31:0]};
      4: return {4'h2, 48'h0, n.parent};
      5: return {4'h1, 56'h0, n.dev_type};
      6: return {4'h1, 56'h0, n.status};
      7: return {4'h2, 48'h0, n.profile};
      default: return {4'h2, 48'h0, n.maker};
    endcase
  endfunction : fld

  // Bus slave: one wait state, data registered
  always_comb begin
    next_ack = (avs_read | avs_write) & ~ack;
    next_rdata = rdata;
    next_api = api;
    next_tmo = tmo;
    next_guard = guard;
    next_esc = esc;
    next_net_id = net_id;
    next_win = win;
    if (avs_read && !ack) begin
      unique case (avs_address)
        OFF_CTRL: next_rdata = {31'h0, api};
        OFF_IDLE: next_rdata = {16'h0, tmo};
        OFF_GUARD: next_rdata = {16'h0, guard};
        OFF_ESC: next_rdata = {24'h0, esc};
        OFF_NET: next_rdata = {16'h0, net_id};
        OFF_WIN: next_rdata = {24'h0, win};
        OFF_STAT: next_rdata = {30'h0, st == S_RES || st == S_DISC, st != S_IDLE};
        OFF_DSTH: next_rdata = dest_hi;
        OFF_DSTL: next_rdata = dest_lo;
        OFF_NVNET: next_rdata = {16'h0, nvnet};
        default: next_rdata = 32'h0; // Unmapped reads zero
      endcase
    end
    // Out-of-range values are ignored, not clamped
    if (avs_write && ack) begin
      unique case (avs_address)
        OFF_CTRL: next_api = avs_writedata[0];
        OFF_IDLE: begin
          if (avs_writedata >= 32'(IDLE_MIN) && avs_writedata <= 32'(IDLE_MAX)) begin
            next_tmo = avs_writedata[15:0];
          end
        end
        OFF_GUARD: next_guard = avs_writedata[15:0];
        OFF_ESC: next_esc = avs_writedata[7:0];
        OFF_NET: begin
          if (avs_writedata <= 32'(NET_MAX)) begin
            next_net_id = avs_writedata[15:0];
          end
        end
        OFF_WIN: begin
          if (avs_writedata <= 32'(WIN_MAX)) begin
            next_win = avs_writedata[7:0];
          end
        end
        default: ;
      endcase
    end
  end

  assign avs_waitrequest = (avs_read | avs_write) & ~ack;
  assign avs_readdata = rdata;

  // Node accepted: same net group and label filter passes
  assign node_ready = (st == S_RES || st == S_DISC) && tcnt == 6'h00;
  assign hit = node_valid && node_ready && node.net == net_id
               && (arg.len == 5'h00 || lab_eq(node.label, arg));

  // Interpreter next state and reply composer
  always_comb begin
    int k;
    logic [67:0] fv;
    k = 0;
    fv = '0;
    next_st = st;
    next_esc_n = esc_n;
    next_left = left;
    next_op = op;
    next_arg = arg;
    next_label = label;
    next_dest_hi = dest_hi;
    next_dest_lo = dest_lo;
    next_start = 1'b0;
    next_nvs = 1'b0;
    next_nvnet = nvnet;
    ld = LD_NONE;
    valid_cmd = 1'b0;
    // Time bases: 1 ms and 100 ms enables
    ms_tick = ms_cnt == 24'(MS_CYC - 1);
    ds_tick = ms_tick && ds_cnt == 7'(DSEC_MS - 1);
    next_ms_cnt = ms_tick ? 24'h0 : ms_cnt + 24'h1;
    next_ds_cnt = ds_tick ? 7'h0 : (ms_tick ? ds_cnt + 7'h1 : ds_cnt);
    next_sil = sil;
    if (rx_valid) begin
      next_sil = 16'h0;
    end else if (ms_tick && sil != 16'hffff) begin
      next_sil = sil + 16'h1;
    end
    next_idle = (ds_tick && idle != 16'hffff) ? idle + 16'h1 : idle;
    unique case (st)
      S_IDLE: begin
        // Each byte either extends the escape run or breaks it
        if (rx_valid) begin
          if (rx_byte == esc && (esc_n != 2'h0 || sil >= guard) && esc_n != 2'(ESC_N)) begin
            next_esc_n = esc_n + 2'h1;
          end else begin
            next_esc_n = 2'h0;
          end
        end else if (esc_n == 2'(ESC_N) && sil >= guard) begin
          next_st = S_OP;
          next_esc_n = 2'h0;
          next_idle = 16'h0;
        end
      end
      S_OP: begin
        if (idle >= tmo) begin
          next_st = S_IDLE;
        end else if (rx_valid && rx_byte != CH_CR) begin
          next_op = rx_byte;
          next_arg = '0;
          next_st = S_ARG;
        end
      end
      S_ARG: begin
        if (idle >= tmo) begin
          next_st = S_IDLE;
        end else if (rx_valid) begin
          if (rx_byte == CH_CR || rx_byte == CH_COMMA) begin
            next_st = S_EXEC;
          end else begin
            next_arg.ch[arg.len] = rx_byte;
            next_arg.len = arg.len + 5'h1;
            if (arg.len == 5'(LABEL_MAX - 1)) begin
              next_st = S_EXEC;
            end
          end
        end
      end
      S_EXEC: begin
        // Waits for the previous reply to drain
        if (tcnt == 6'h00) begin
          next_st = S_OP;
          valid_cmd = 1'b1;
          ld = LD_OK;
          next_left = win;
          if (op == OP_LEAVE) begin
            next_st = S_IDLE;
          end else if (op == OP_SAVE) begin
            next_nvs = 1'b1;
            next_nvnet = net_id;
          end else if (op == OP_LABEL) begin
            if (lab_ok(arg)) begin
              next_label = arg;
            end else begin
              ld = LD_ERR;
            end
          end else if (op == OP_RESOLVE) begin
            ld = (arg.len == 5'h00) ? LD_ERR : LD_NONE;
            next_start = arg.len != 5'h00;
            next_st = (arg.len == 5'h00) ? S_OP : S_RES;
          end else if (op == OP_DISC) begin
            ld = LD_NONE;
            next_start = 1'b1;
            next_st = S_DISC;
          end else begin
            ld = LD_ERR;
            valid_cmd = 1'b0;
          end
          if (valid_cmd) begin
            next_idle = 16'h0;
          end
        end
      end
      S_RES, S_DISC: begin
        if (hit && st == S_RES) begin
          next_dest_hi = node.serial[63:32];
          next_dest_lo = node.serial[31:0];
          ld = api ? LD_FRM : LD_OK;
          next_st = api ? S_OP : S_IDLE;
          next_idle = 16'h0;
        end else if (hit) begin
          ld = LD_REP;
        end else if (ds_tick && left != 8'h0) begin
          next_left = left - 8'h1;
        end else if (left == 8'h0 && tcnt == 6'h00) begin
          ld = (st == S_RES) ? LD_ERR : (api ? LD_NONE : LD_CR);
          next_st = S_OP;
          next_idle = 16'h0;
        end
      end
    endcase
    // Drain one byte per accepted transfer
    next_tbuf = tbuf;
    next_tcnt = tcnt;
    if (tx_valid && tx_ready) begin
      next_tbuf = {8'h00, tbuf[TBUF_N-1:1]};
      next_tcnt = tcnt - 6'h1;
    end
    // New replies load only into an empty buffer
    if (ld != LD_NONE) begin
      next_tbuf = '0;
      unique case (ld)
        LD_OK: begin
          for (int i = 0; i < 3; i++) next_tbuf[i] = MSG_OK[8*(2-i)+:8];
          k = 3;
        end
        LD_ERR: begin
          for (int i = 0; i < 6; i++) next_tbuf[i] = MSG_ERR[8*(5-i)+:8];
          k = 6;
        end
        LD_CR: begin
          next_tbuf[0] = CH_CR;
          k = 1;
        end
        LD_FRM: begin
          next_tbuf[0] = RES_SHORT[15:8];
          next_tbuf[1] = RES_SHORT[7:0];
          for (int i = 0; i < 8; i++) next_tbuf[2+i] = node.serial[8*(7-i)+:8];
          k = 10;
        end
        default: begin
          for (int f = 0; f < 9; f++) begin
            if (f == 3) begin
              for (int j = 0; j < LABEL_MAX; j++) begin
                if (j < node.label.len) begin
                  next_tbuf[k] = node.label.ch[j];
                  k = k + 1;
                end
              end
              if (api) begin
                next_tbuf[k] = CH_NUL;
                k = k + 1;
              end
            end else begin
              fv = fld(f, node);
              for (int j = 7; j >= 0; j--) begin
                if (j < int'(fv[67:64])) begin
                  next_tbuf[k] = fv[8*j+:8];
                  k = k + 1;
                end
              end
            end
            if (!api) begin
              next_tbuf[k] = CH_CR;
              k = k + 1;
            end
          end
        end
      endcase
      next_tcnt = 6'(k);
    end
  end

  // Register all state
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      ack <= 1'b0;
      rdata <= 32'h0;
      api <= 1'b0;
      tmo <= IDLE_RST;
      guard <= GUARD_RST;
      esc <= ESC_RST;
      net_id <= NET_MAX;
      win <= WIN_RST;
      st <= S_IDLE;
      esc_n <= 2'h0;
      sil <= 16'h0;
      idle <= 16'h0;
      ms_cnt <= 24'h0;
      ds_cnt <= 7'h0;
      left <= 8'h0;
      op <= 8'h00;
      arg <= '0;
      label <= LABEL_RST;
      dest_hi <= 32'h0;
      dest_lo <= 32'h0;
      tbuf <= '0;
      tcnt <= 6'h00;
      start <= 1'b0;
      nvs <= 1'b0;
      nvnet <= NET_MAX;
    end else begin
      ack <= next_ack;
      rdata <= next_rdata;
      api <= next_api;
      tmo <= next_tmo;
      guard <= next_guard;
      esc <= next_esc;
      net_id <= next_net_id;
      win <= next_win;
      st <= next_st;
      esc_n <= next_esc_n;
      sil <= next_sil;
      idle <= next_idle;
      ms_cnt <= next_ms_cnt;
      ds_cnt <= next_ds_cnt;
      left <= next_left;
      op <= next_op;
      arg <= next_arg;
      label <= next_label;
      dest_hi <= next_dest_hi;
      dest_lo <= next_dest_lo;
      tbuf <= next_tbuf;
      tcnt <= next_tcnt;
      start <= next_start;
      nvs <= next_nvs;
      nvnet <= next_nvnet;
    end
  end

  assign tx_valid = tcnt != 6'h00;
  assign tx_byte = tbuf[0];
  assign disc_start = start;
  assign net_group = net_id;
  assign nv_save = nvs;
  assign nv_net_group = nvnet;
  assign cmd_mode = st != S_IDLE;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence s_exec(logic [7:0] c);
    st == S_EXEC && tcnt == 6'h00 && op == c;
  endsequence
  sequence s_res_hit;
    st == S_RES && hit;
  endsequence
  a_idle_exit: assert property ((st == S_OP || st == S_ARG) && idle >= tmo |=> !cmd_mode)
    else $error("idle timeout did not exit");
  a_leave_now: assert property (s_exec(OP_LEAVE) |=> !cmd_mode ##1 !cmd_mode)
    else $error("leave did not exit");
  a_guard_entry: assert property ($rose(cmd_mode) |-> $past(esc_n) == 2'(ESC_N) && $past(sil) >= guard)
    else $error("entry without guard");
  a_esc_break: assert property (st == S_IDLE && rx_valid && rx_byte != esc |=> esc_n == 2'h0)
    else $error("escape run not broken");
  // Window end may load its own reply in the same cycle, so only mid-window answers count
  a_net_filter: assert property (node_valid && node_ready && node.net != net_id && left != 8'h0 |=> tcnt == 6'h00)
    else $error("foreign net accepted");
  a_save_copy: assert property (nv_save |-> nv_net_group == $past(net_id) && !$past(nv_save))
    else $error("save copy wrong");
  a_label_form: assert property (label.len >= 5'h01 && label.len <= 5'(LABEL_MAX))
    else $error("label length bad");
  a_res_load: assert property (s_res_hit ##0 !api |=> dest_lo == $past(node.serial[31:0]) && !cmd_mode
    && tbuf[0] == MSG_OK[23:16])
    else $error("resolve hit sequence wrong");
  a_res_frame: assert property (s_res_hit ##0 api |=> tcnt == 6'ha && tbuf[0] == RES_SHORT[15:8])
    else $error("framed resolve wrong");
  a_res_miss: assert property (st == S_RES && !hit && left == 8'h0 && tcnt == 6'h00 |=> st == S_OP
    && tcnt == 6'h06)
    else $error("resolve miss wrong");
  a_disc_end: assert property (st == S_DISC && !hit && left == 8'h0 && tcnt == 6'h00 && !api |=>
    tcnt == 6'h01 && tbuf[0] == CH_CR)
    else $error("discovery end wrong");
  a_cmd_restart: assert property (s_exec(OP_SAVE) |=> idle == 16'h0)
    else $error("idle not restarted");
endmodule : cmnd_core

//--- sim/cmnd_node_model.sv
// Remote radio node seen from the interpreter: answers each discovery request.
// Assumes the same clock as the core; answer and delay are set by the bench.
`timescale 1ns/1ps
module cmnd_node_model
  import cmnd_pkg::*;
(
  input wire logic core_clk,
  input wire logic disc_start,
  input wire logic node_ready,
  input wire logic answer_en,
  input wire logic [7:0] answer_dly,
  input wire cmnd_node_t answer,
  output logic node_valid = 1'b0,
  output cmnd_node_t node = '0
);
  int dly = 0; // Cycles left before the answer is offered
  // Offer after a delay, hold until taken, then scramble the released data
  always @(posedge core_clk) begin
    if (disc_start && answer_en) begin
      dly <= int'(answer_dly) + 1;
    end else if (dly > 1) begin
      dly <= dly - 1;
    end else if (dly == 1) begin
      node_valid <= 1'b1;
      node <= answer;
      dly <= 0;
    end else if (node_valid && node_ready) begin
      // Stale data must not look valid after release
      node_valid <= 1'b0;
      node <= ~answer;
    end
  end
endmodule : cmnd_node_model

//--- sim/testbench.sv
// Self-checking bench for the command-mode interpreter.
// Assumes the core with MS_CYC shortened to 20 cycles per millisecond.
`timescale 1ns/1ps
module testbench;
  import cmnd_pkg::*;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [5:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic rx_valid = 1'b0;
  logic [7:0] rx_byte = '0;
  logic tx_valid;
  logic [7:0] tx_byte;
  logic tx_ready = 1'b1; // Host always drains replies
  logic disc_start, node_valid, node_ready, nv_save, cmd_mode;
  logic [15:0] net_group, nv_net_group;
  cmnd_node_t node, ans;
  logic [7:0] rxq[$]; // Bytes sent back to the host
  logic [31:0] r;
  int error_cnt = 0;
  int tests_run = 0;
  int saves = 0;
  cmnd_core #(.MS_CYC(20)) dut (.core_clk(core_clk), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rx_valid(rx_valid),
    .rx_byte(rx_byte), .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_ready(tx_ready),
    .disc_start(disc_start), .net_group(net_group), .node_valid(node_valid), .node(node),
    .node_ready(node_ready), .nv_save(nv_save), .nv_net_group(nv_net_group), .cmd_mode(cmd_mode));
  cmnd_node_model peer (.core_clk(core_clk), .disc_start(disc_start), .node_ready(node_ready),
    .answer_en(1'b1), .answer_dly(8'h1e), .answer(ans), .node_valid(node_valid), .node(node));
  initial begin
    forever #20 core_clk = ~core_clk;
  end
  // Collect host-bound bytes and save pulses
  always @(posedge core_clk) begin
    if (tx_valid === 1'b1 && tx_ready) rxq.push_back(tx_byte);
    if (nv_save === 1'b1) saves <= saves + 1;
  end
  task automatic conclude;
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One Avalon transfer; held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int i;
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    // Waitrequest and read data are both taken at the same rising edge
    for (i = 0; i < 20; i++) begin
      @(posedge core_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (i == 20) begin
      error_cnt++;
      conclude();
    end
    r = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic rd(input logic [5:0] a, input logic [31:0] exp);
    bus(1'b0, a, '0);
    chk(r, exp);
  endtask : rd
  task automatic send(input logic [7:0] b);
    @(posedge core_clk);
    rx_valid <= 1'b1;
    rx_byte <= b;
    @(posedge core_clk);
    rx_valid <= 1'b0;
  endtask : send
  task automatic line(input string s);
    foreach (s[i]) send(s[i]);
    send(CH_CR);
  endtask : line
  task automatic expect_q(input logic [7:0] e[$]);
    int n;
    for (n = 0; n < 12000 && rxq.size() < e.size(); n++) @(posedge core_clk);
    if (n == 12000) begin
      error_cnt++;
      conclude();
    end
    foreach (e[i]) chk({24'h0, rxq[i]}, {24'h0, e[i]});
    rxq.delete();
  endtask : expect_q
  task automatic expect_str(input string s);
    logic [7:0] e[$];
    foreach (s[i]) e.push_back(s[i]);
    e.push_back(CH_CR);
    expect_q(e);
  endtask : expect_str
  task automatic wait_mode(input logic v, input int n);
    int i;
    for (i = 0; i < n && cmd_mode !== v; i++) @(negedge core_clk);
    chk({31'h0, cmd_mode}, {31'h0, v});
  endtask : wait_mode
  // Guard silence, three escapes, guard silence (guard set to 2 ms)
  task automatic enter;
    repeat (60) @(posedge core_clk);
    repeat (ESC_N) send(8'h41);
    repeat (60) @(posedge core_clk);
    wait_mode(1'b1, 100);
  endtask : enter
  // Main sequence
  initial begin
    ans = '0;
    ans.net = 16'h1234;
    ans.short_addr = 16'h00a1;
    ans.serial = 64'h0102030405060708;
    ans.label.ch[0] = 8'h41;
    ans.label.ch[1] = 8'h62;
    ans.label.len = 5'h02;
    ans.parent = 16'hbeef;
    ans.dev_type = 8'h01;
    ans.profile = 16'hc105;
    ans.maker = 16'h101e;
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    rd(OFF_IDLE, 32'h64);
    rd(OFF_GUARD, 32'h3e8);
    rd(OFF_ESC, 32'h2b);
    rd(OFF_NET, 32'h7fff);
    rd(OFF_WIN, 32'h82);
    rd(OFF_STAT, 32'h0);
    rd(6'h28, 32'h0);
    // Out-of-range settings are refused
    bus(1'b1, OFF_IDLE, 32'h1);
    bus(1'b1, OFF_NET, 32'h8000);
    bus(1'b1, OFF_WIN, 32'hfd);
    rd(OFF_IDLE, 32'h64);
    rd(OFF_NET, 32'h7fff);
    rd(OFF_WIN, 32'h82);
    bus(1'b1, OFF_GUARD, 32'h2);
    bus(1'b1, OFF_ESC, 32'h41);
    bus(1'b1, OFF_IDLE, 32'h2);
    bus(1'b1, OFF_WIN, 32'h1);
    bus(1'b1, OFF_NET, 32'h1234);
    // The write lands at the release edge; look once it has settled
    @(negedge core_clk);
    chk({16'h0, net_group}, 32'h1234);
    // Trailing silence broken by a stray byte: no entry
    repeat (60) @(posedge core_clk);
    repeat (ESC_N) send(8'h41);
    send(8'h51);
    repeat (100) @(posedge core_clk);
    chk({31'h0, cmd_mode}, 32'h0);
    enter();
    line("W");
    expect_str("OK");
    chk(saves, 1);
    rd(OFF_NVNET, 32'h1234);
    line("L ab");
    expect_str("ERROR");
    line("LAb");
    expect_str("OK");
    // Case differs: no match, window runs out
    line("Rab");
    expect_str("ERROR");
    chk({31'h0, cmd_mode}, 32'h1);
    line("R");
    expect_str("ERROR");
    line("DZz");
    expect_q('{8'h0d});
    // Answer from a foreign net group is dropped
    ans.net = 16'h4321;
    line("D");
    expect_q('{8'h0d});
    ans.net = 16'h1234;
    line("D");
    expect_q('{8'h00, 8'ha1, 8'h0d, 8'h01, 8'h02, 8'h03, 8'h04, 8'h0d, 8'h05, 8'h06, 8'h07, 8'h08, 8'h0d,
      8'h41, 8'h62, 8'h0d, 8'hbe, 8'hef, 8'h0d, 8'h01, 8'h0d, 8'h00, 8'h0d, 8'hc1, 8'h05, 8'h0d,
      8'h10, 8'h1e, 8'h0d, 8'h0d});
    line("RAb");
    expect_str("OK");
    chk({31'h0, cmd_mode}, 32'h0);
    rd(OFF_DSTH, 32'h01020304);
    rd(OFF_DSTL, 32'h05060708);
    enter();
    line("X");
    expect_str("OK");
    wait_mode(1'b0, 4);
    // Framed mode: binary resolve answer, reports without CRs
    bus(1'b1, OFF_CTRL, 32'h1);
    enter();
    line("RAb");
    expect_q('{8'hff, 8'hfe, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08});
    chk({31'h0, cmd_mode}, 32'h1);
    line("D");
    expect_q('{8'h00, 8'ha1, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h41, 8'h62,
      8'h00, 8'hbe, 8'hef, 8'h01, 8'h00, 8'hc1, 8'h05, 8'h10, 8'h1e});
    // No closing byte in framed mode: let the window run out
    repeat (2000) @(posedge core_clk);
    rd(OFF_STAT, 32'h1);
    line("X");
    expect_str("OK");
    enter();
    // Earliest timeout is about 2000 cycles after entry
    repeat (1500) @(posedge core_clk);
    chk({31'h0, cmd_mode}, 32'h1);
    wait_mode(1'b0, 5000);
    conclude();
  end
endmodule : testbench
